// File: rtl/scl_pkg.sv
package scl_pkg;

    // ------------------------------------------------------------
    // Command groups (upper nibble)
    // ------------------------------------------------------------
    localparam logic [3:0] GRP_FOCUS    = 4'h0;
    localparam logic [3:0] GRP_TRACK    = 4'h1;
    localparam logic [3:0] GRP_MODE     = 4'h2;
    localparam logic [3:0] GRP_ADJUST   = 4'h3;

    // ------------------------------------------------------------
    // Data field positions (lower nibble)
    // ------------------------------------------------------------
    localparam int FOCUS_SERVO_POS    = 3;
    localparam int FLAW_DISABLE_POS   = 2;
    localparam int SEARCH_ENABLE_POS  = 1;
    localparam int SEARCH_DIR_POS     = 0;
    localparam int GAIN_BOOST_POS     = 3;
    localparam int BRAKE_POS          = 2;
    localparam int ADJ_SELECT_POS     = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_FOCUS    = 8'h00;
    localparam logic [7:0] RST_TRACK    = 8'h10;
    localparam logic [7:0] RST_MODE     = 8'h20;
    localparam logic [7:0] RST_BALANCE  = 8'h37;
    localparam logic [7:0] RST_GAIN     = 8'h38;
    localparam logic [2:0] RST_BAL_SW   = 3'h0;
    localparam logic [2:0] RST_GAIN_SW  = 3'h7;

    // ------------------------------------------------------------
    // Timing of the host link
    // ------------------------------------------------------------
    localparam int MCLK_HZ          = 10_000_000;
    localparam int LATCH_MIN_NS     = 1000;
    localparam int LATCH_MIN_CYC    = (LATCH_MIN_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

    // Sense output source selection
    typedef enum logic [2:0] {
        SCL_MONITOR_OUTPUT_FOCUS_ZC,
        SCL_MONITOR_OUTPUT_FLAW,
        SCL_MONITOR_OUTPUT_TRACK_ZC,
        SCL_MONITOR_OUTPUT_ADJ_LPF,
        SCL_MONITOR_OUTPUT_ADJ_HPF,
        SCL_MONITOR_OUTPUT_HIGHZ
    } scl_monitor_output_t;

    typedef struct packed {
        logic       focus_servo_switch;
        logic       flaw_disable;
        logic       search_enable;
        logic       search_direction;
    } scl_focus_t;

    typedef struct packed {
        logic       track_gain_boost_a;
        logic       track_gain_boost_b;
        logic       brake_switch;
        logic       sled_height_hi;
        logic       sled_height_lo;
    } scl_track_t;

    typedef struct packed {
        logic [1:0] tracking_mode;
        logic [1:0] sled_mode;
    } scl_mode_t;

    // Comparator and detector levels from the analog side
    typedef struct packed {
        logic       focus_null_cross;
        logic       track_null_cross;
        logic       flaw_detect;
        logic       adj_lpf_cmp;
        logic       adj_hpf_cmp;
    } scl_sense_in_t;

endpackage : scl_pkg

// File: rtl/scl_servo_latch.sv
`timescale 1ns/1ps
// Behaviour
// - Focus group D3..D0 map to focus switches
// - Focus servo switch connects error path
// - Flaw switch closes on flaw unless disabled
// - Search voltage passed only when enabled
// - Direction bit adds reversing current source
// - Sense mux follows latest command group
// - D3 drives both gain boosts; D2 brake
// - D1 D0 select sled kick height
// - Brake uses opposite-phase envelope cutting
// - Mode group sets tracking and sled modes
// - Reset: balance off, gain on
// - Adjust D3=0 loads balance, selects LPF
// - Adjust D3=1 keeps balance unchanged
// - Adjust D3=1 loads gain, selects HPF
// - New data applied only on latch
// - Adjust switches are inverse of data
// - Reset groups 00, 10, 20, 37, 38
module scl_servo_latch
    import scl_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          resetn,
    input  wire logic          link_clk,
    input  wire logic          link_data,
    input  wire logic          link_latch,
    input  wire scl_sense_in_t sense_in,
    output scl_focus_t         focus_state,
    output scl_track_t         track_state,
    output scl_mode_t          mode_state,
    output logic               media_flaw_switch,
    output logic               focus_path_on,
    output logic               search_pass,
    output logic               search_reverse_src,
    output logic               brake_active,
    output logic [2:0]         balance_switch,
    output logic [2:0]         gain_switch,
    output logic               track_jump_fwd,
    output logic               track_jump_rev,
    output logic               sled_move_fwd,
    output logic               sled_move_rev,
    output logic               tracking_servo_on,
    output logic               sled_servo_on,
    output logic               monitor_output,
    output logic               monitor_output_oe,
    output logic [2:0]         monitor_output_sel
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0]          latch_sync;
    scl_sense_in_t       sense_s1;
    scl_sense_in_t       sense_s2;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            latch_sync <= 2'h0;
            sense_s1   <= '0;
            sense_s2   <= '0;
        end else begin
            latch_sync <= {latch_sync[0], link_latch};
            sense_s1   <= sense_in;
            sense_s2   <= sense_s1;
        end
    end

    // ------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------
    logic [7:0] cmd_word;
    logic       cmd_level;
    logic       cmd_seen;

    scl_shift_rx u_rx (
        .link_clk   (link_clk),
        .link_data  (link_data),
        .latch_hold (latch_sync[1]),
        .mclk       (mclk),
        .resetn     (resetn),
        .cmd_word   (cmd_word),
        .cmd_toggle (cmd_level)
    );

    // Rising edge of the synchronised latch: the word was captured this cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmd_seen <= 1'b0;
        end else begin
            cmd_seen <= cmd_level;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire        cmd_fire   = cmd_level & ~cmd_seen;
    wire [3:0]  cmd_group  = cmd_word[7:4];
    wire [3:0]  cmd_data   = cmd_word[3:0];
    wire        hit_focus  = cmd_fire & (cmd_group == GRP_FOCUS);
    wire        hit_track  = cmd_fire & (cmd_group == GRP_TRACK);
    wire        hit_mode   = cmd_fire & (cmd_group == GRP_MODE);
    wire        hit_adjust = cmd_fire & (cmd_group == GRP_ADJUST);
    wire        adj_gain   = cmd_data[ADJ_SELECT_POS];
    wire        hit_bal    = hit_adjust & ~adj_gain;
    wire        hit_gain   = hit_adjust &  adj_gain;

    wire scl_focus_t next_focus = '{
        focus_servo_switch: cmd_data[FOCUS_SERVO_POS],
        flaw_disable:       cmd_data[FLAW_DISABLE_POS],
        search_enable:      cmd_data[SEARCH_ENABLE_POS],
        search_direction:   cmd_data[SEARCH_DIR_POS]};

    wire scl_track_t next_track = '{
        track_gain_boost_a: cmd_data[GAIN_BOOST_POS],
        track_gain_boost_b: cmd_data[GAIN_BOOST_POS],
        brake_switch:       cmd_data[BRAKE_POS],
        sled_height_hi:     cmd_data[1],
        sled_height_lo:     cmd_data[0]};

    // Switch is on when its data bit is 0
    wire [2:0]  next_adj_sw = ~cmd_data[2:0];

    // Groups 4..15 select high-Z and touch no switch state
    scl_monitor_output_t next_monitor_output;
    always_comb begin
        next_monitor_output = scl_monitor_output_t'(monitor_output_sel);
        if (cmd_fire) begin
            case (cmd_group)
                GRP_FOCUS:  next_monitor_output = SCL_MONITOR_OUTPUT_FOCUS_ZC;
                GRP_TRACK:  next_monitor_output = SCL_MONITOR_OUTPUT_FLAW;
                GRP_MODE:   next_monitor_output = SCL_MONITOR_OUTPUT_TRACK_ZC;
                GRP_ADJUST: next_monitor_output = adj_gain ? SCL_MONITOR_OUTPUT_ADJ_HPF : SCL_MONITOR_OUTPUT_ADJ_LPF;
                default:    next_monitor_output = SCL_MONITOR_OUTPUT_HIGHZ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Latched switch state
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            focus_state    <= scl_focus_t'(RST_FOCUS[3:0]);
            track_state    <= scl_track_t'({RST_TRACK[3], RST_TRACK[3:0]});
            mode_state     <= scl_mode_t'(RST_MODE[3:0]);
            balance_switch <= RST_BAL_SW;
            gain_switch    <= RST_GAIN_SW;
            monitor_output_sel       <= 3'(SCL_MONITOR_OUTPUT_FOCUS_ZC);
        end else begin
            if (hit_focus)  focus_state    <= next_focus;
            if (hit_track)  track_state    <= next_track;
            if (hit_mode)   mode_state     <= scl_mode_t'(cmd_data);
            if (hit_bal)    balance_switch <= next_adj_sw;
            if (hit_gain)   gain_switch    <= next_adj_sw;
            monitor_output_sel <= 3'(next_monitor_output);
        end
    end

    // ------------------------------------------------------------
    // Switch drive, all registered
    // ------------------------------------------------------------
    wire next_flaw   = ~focus_state.flaw_disable & sense_s2.flaw_detect;
    wire [1:0] tmode = mode_state.tracking_mode;
    wire [1:0] smode = mode_state.sled_mode;

    // Sense mux value; the analog comparators are two-flop synchronised
    logic next_mon;
    always_comb begin
        case (scl_monitor_output_t'(monitor_output_sel))
            SCL_MONITOR_OUTPUT_FOCUS_ZC: next_mon = sense_s2.focus_null_cross;
            SCL_MONITOR_OUTPUT_FLAW:     next_mon = sense_s2.flaw_detect;
            SCL_MONITOR_OUTPUT_TRACK_ZC: next_mon = sense_s2.track_null_cross;
            SCL_MONITOR_OUTPUT_ADJ_LPF:  next_mon = sense_s2.adj_lpf_cmp;
            SCL_MONITOR_OUTPUT_ADJ_HPF:  next_mon = sense_s2.adj_hpf_cmp;
            default:           next_mon = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            media_flaw_switch  <= 1'b0;
            focus_path_on      <= 1'b0;
            search_pass        <= 1'b0;
            search_reverse_src <= 1'b0;
            brake_active       <= 1'b0;
            tracking_servo_on  <= 1'b0;
            track_jump_fwd     <= 1'b0;
            track_jump_rev     <= 1'b0;
            sled_servo_on      <= 1'b0;
            sled_move_fwd      <= 1'b0;
            sled_move_rev      <= 1'b0;
            monitor_output     <= 1'b0;
            monitor_output_oe  <= 1'b0;
        end else begin
            media_flaw_switch  <= next_flaw;
            focus_path_on      <= focus_state.focus_servo_switch;
            search_pass        <= focus_state.search_enable;
            search_reverse_src <= focus_state.search_direction;
            // Brake acts only while the brake switch is closed
            brake_active       <= track_state.brake_switch;
            tracking_servo_on  <= (tmode == 2'h1);
            track_jump_fwd     <= (tmode == 2'h2);
            track_jump_rev     <= (tmode == 2'h3);
            sled_servo_on      <= (smode == 2'h1);
            sled_move_fwd      <= (smode == 2'h2);
            sled_move_rev      <= (smode == 2'h3);
            monitor_output     <= next_mon;
            monitor_output_oe  <= (scl_monitor_output_t'(monitor_output_sel) != SCL_MONITOR_OUTPUT_HIGHZ);
        end
    end

endmodule : scl_servo_latch

// File: rtl/scl_shift_rx.sv
`timescale 1ns/1ps
// Link-clock side: shift register plus latch capture. The synchronised latch
// level is passed on one cycle late, so the top forms one strobe per pulse.
module scl_shift_rx
    import scl_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       link_data,
    input  wire logic       latch_hold,
    input  wire logic       mclk,
    input  wire logic       resetn,
    output logic [7:0]      cmd_word,
    output logic            cmd_toggle
);

    logic [7:0] shift_reg;

    // ------------------------------------------------------------
    // Serial shift, MSB first
    // ------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        shift_reg <= {shift_reg[6:0], link_data};
    end

    // ------------------------------------------------------------
    // Capture on latch, in mclk domain
    // ------------------------------------------------------------
    // The link clock is idle while latch is high, so the shift word is stable
    // for the whole pulse; sampling it from mclk is then safe.
    logic latch_d;

    assign cmd_toggle = latch_d;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmd_word <= 8'h00;
            latch_d  <= 1'b0;
        end else begin
            latch_d <= latch_hold;
            if (latch_hold && !latch_d) begin
                cmd_word <= shift_reg;
            end
        end
    end

endmodule : scl_shift_rx

// File: tb/scl_host_model.sv
`timescale 1ns/1ps
// Host side of the serial link; the link clock only runs inside a frame
module scl_host_model (
    output logic link_clk,
    output logic link_data,
    output logic link_latch
);
    initial begin
        link_clk = 1'b0;
        link_data = 1'b0;
        link_latch = 1'b0;
    end

    task automatic send(input logic [7:0] cmd);
        #7;
        for (int i = 7; i >= 0; i--) begin
            link_data = cmd[i];
            // Bench link runs far faster than a real host; the receiver must not care
            #15 link_clk = 1'b1;
            #15 link_clk = 1'b0;
        end
        // Data line no longer held: show the inverse of the last bit
        link_data = ~cmd[0];
        #15 link_latch = 1'b1;
        #(scl_pkg::LATCH_MIN_NS) link_latch = 1'b0;
        #(scl_pkg::LATCH_MIN_NS);
    endtask : send
endmodule : scl_host_model

// File: tb/scl_servo_latch_assertions.sv
`timescale 1ns/1ps
module scl_servo_latch_assertions
    import scl_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       link_latch,
    input wire scl_focus_t focus_state,
    input wire scl_track_t track_state,
    input wire scl_mode_t  mode_state,
    input wire logic       media_flaw_switch,
    input wire logic       focus_path_on,
    input wire logic       search_pass,
    input wire logic       search_reverse_src,
    input wire logic       brake_active,
    input wire logic [2:0] balance_switch,
    input wire logic [2:0] gain_switch,
    input wire logic       tracking_servo_on,
    input wire logic       sled_move_rev,
    input wire logic       monitor_output_oe,
    input wire logic [2:0] monitor_output_sel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Latch synchroniser needs a few cycles, so five quiet cycles mean no update
    sequence quiet_link;
        !link_latch [*5];
    endsequence
    sequence gain_load;
        $changed(gain_switch);
    endsequence
    chk_focus_copy: assert property (
        {focus_path_on, search_pass, search_reverse_src} == {$past(focus_state.focus_servo_switch),
        $past(focus_state.search_enable), $past(focus_state.search_direction)})
        else $error("focus switch outputs differ from focus state");
    chk_flaw_hold: assert property (
        focus_state.flaw_disable [*3] |-> !media_flaw_switch)
        else $error("flaw switch closed while disabled");
    chk_brake_copy: assert property (
        brake_active == $past(track_state.brake_switch))
        else $error("brake output differs from brake switch");
    chk_mode_decode: assert property (
        tracking_servo_on == ($past(mode_state.tracking_mode) == 2'b01) &&
        sled_move_rev == ($past(mode_state.sled_mode) == 2'b11))
        else $error("mode decode wrong");
    chk_gain_select: assert property (
        gain_load |-> ##[0:2] monitor_output_sel == 3'h4)
        else $error("gain load without high-pass select");
    chk_balance_select: assert property (
        $changed(balance_switch) |-> ##[0:2] monitor_output_sel == 3'h3)
        else $error("balance change without low-pass select");
    chk_monitor_output_highz: assert property (
        (monitor_output_sel == 3'h5) [*2] |-> !monitor_output_oe)
        else $error("monitor driven in high impedance group");
    chk_monitor_output_drive: assert property (
        (monitor_output_sel != 3'h5) [*2] |-> monitor_output_oe)
        else $error("monitor not driven");
    chk_hold_state: assert property (
        quiet_link |-> $stable(focus_state) && $stable(track_state) && $stable(mode_state)
        && $stable(balance_switch) && $stable(gain_switch))
        else $error("state changed without latch");
endmodule : scl_servo_latch_assertions

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import scl_pkg::*;
    logic mclk, resetn, link_clk, link_data, link_latch;
    scl_sense_in_t sense_in;
    scl_focus_t focus_state;
    scl_track_t track_state;
    scl_mode_t mode_state;
    logic flaw_sw, path_on, s_pass, s_rev, brake, t_on, j_fwd, j_rev, s_on, m_fwd, m_rev;
    logic mon, mon_oe;
    logic [2:0] bal, gain, sel, e_bal, e_gain, e_sel;
    logic [3:0] e_focus, e_mode;
    logic [4:0] e_track;
    int seed = 36701;
    int mismatches = 0;
    int check_count = 0;
    localparam logic [7:0] CORNER [27] = '{8'h08, 8'h00, 8'h02, 8'h03, 8'h02, 8'h03, 8'h04,
        8'h0F, 8'h1F, 8'h13, 8'h10, 8'h1A, 8'h24, 8'h2F, 8'h28, 8'h21, 8'h2E, 8'h30, 8'h37,
        8'h35, 8'h3A, 8'h3D, 8'h38, 8'h3F, 8'h45, 8'h7F, 8'h02};

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    scl_host_model i_host (.link_clk(link_clk), .link_data(link_data), .link_latch(link_latch));

    scl_servo_latch i_dut (.mclk(mclk), .resetn(resetn), .link_clk(link_clk),
        .link_data(link_data), .link_latch(link_latch), .sense_in(sense_in),
        .focus_state(focus_state), .track_state(track_state), .mode_state(mode_state),
        .media_flaw_switch(flaw_sw), .focus_path_on(path_on), .search_pass(s_pass),
        .search_reverse_src(s_rev), .brake_active(brake), .balance_switch(bal),
        .gain_switch(gain), .track_jump_fwd(j_fwd), .track_jump_rev(j_rev),
        .sled_move_fwd(m_fwd), .sled_move_rev(m_rev), .tracking_servo_on(t_on),
        .sled_servo_on(s_on), .monitor_output(mon), .monitor_output_oe(mon_oe), .monitor_output_sel(sel));

    function automatic logic [2:0] sel_of(input logic [7:0] c);
        case (c[7:4])
            4'h0, 4'h1, 4'h2: return c[6:4];
            4'h3: return c[3] ? 3'h4 : 3'h3;
            default: return 3'h5;
        endcase
    endfunction : sel_of

    function automatic logic src_of(input logic [2:0] s, input scl_sense_in_t si);
        logic [4:0] v;
        v = {si.focus_null_cross, si.flaw_detect, si.track_null_cross, si.adj_lpf_cmp,
            si.adj_hpf_cmp};
        return v[3'h4 - s];
    endfunction : src_of

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic check_all();
        check(8'(focus_state), {4'h0, e_focus}, "focus");
        check(8'(track_state), {3'h0, e_track}, "track");
        check(8'(mode_state), {4'h0, e_mode}, "mode");
        check({bal, gain, 2'h0}, {e_bal, e_gain, 2'h0}, "bal gain");
        check({2'h0, t_on, j_fwd, j_rev, s_on, m_fwd, m_rev}, {2'h0, e_mode[3:2] == 2'h1,
            e_mode[3:2] == 2'h2, e_mode[3:2] == 2'h3, e_mode[1:0] == 2'h1,
            e_mode[1:0] == 2'h2, e_mode[1:0] == 2'h3}, "mode decode");
        check({3'h0, path_on, s_pass, s_rev, brake, flaw_sw}, {3'h0, e_focus[3], e_focus[1],
            e_focus[0], e_track[2], sense_in.flaw_detect & ~e_focus[2]}, "switches");
        check({4'h0, sel, mon_oe}, {4'h0, e_sel, e_sel != 3'h5}, "sense select");
        if (e_sel != 3'h5)
            check({7'h0, mon}, {7'h0, src_of(e_sel, sense_in)}, "monitor");
    endtask : check_all

    task automatic apply(input logic [7:0] c);
        @(negedge mclk);
        sense_in = scl_sense_in_t'(5'($random(seed)));
        i_host.send(c);
        case (c[7:4])
            4'h0: e_focus = c[3:0];
            4'h1: e_track = {c[3], c[3:0]};
            4'h2: e_mode = c[3:0];
            4'h3: if (c[3]) e_gain = ~c[2:0]; else e_bal = ~c[2:0];
            default: ;
        endcase
        e_sel = sel_of(c);
        @(negedge mclk);
        check_all();
    endtask : apply

    task automatic do_reset();
        @(negedge mclk);
        resetn = 1'b0;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        e_focus = RST_FOCUS[3:0];
        e_track = {RST_TRACK[3], RST_TRACK[3:0]};
        e_mode = RST_MODE[3:0];
        e_bal = ~RST_BALANCE[2:0];
        e_gain = ~RST_GAIN[2:0];
        e_sel = sel_of(RST_FOCUS);
        repeat (3) @(negedge mclk);
        check_all();
    endtask : do_reset

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #1_000_000;
        mismatches++;
        $display("unexpected at %0t: watchdog ran out", $time);
        give_verdict();
    end

    initial begin
        resetn = 1'b0;
        sense_in = '0;
        do_reset();
        $display("reset test done");
        foreach (CORNER[i]) apply(CORNER[i]);
        $display("corner test done");
        repeat (40) apply(8'($random(seed)) & 8'h7F);
        $display("random test done");
        do_reset();
        $display("second reset test done");
        give_verdict();
    end
endmodule : testbench

bind scl_servo_latch scl_servo_latch_assertions i_chk (.mclk(mclk), .resetn(resetn),
    .link_latch(link_latch), .focus_state(focus_state), .track_state(track_state),
    .mode_state(mode_state), .media_flaw_switch(media_flaw_switch),
    .focus_path_on(focus_path_on), .search_pass(search_pass),
    .search_reverse_src(search_reverse_src), .brake_active(brake_active),
    .balance_switch(balance_switch), .gain_switch(gain_switch),
    .tracking_servo_on(tracking_servo_on), .sled_move_rev(sled_move_rev),
    .monitor_output_oe(monitor_output_oe), .monitor_output_sel(monitor_output_sel));
